// file: rtl/adcsp_pkg.sv
/*
  Constants, register layout and helper functions for the converter serial port block.
  Assumes one system clock; serial, master clock and sync pin levels are synchronised inside the block before use.
*/
// Function
// - The port answers serial clock edges only while the active-low chip select is low.
// - With chip select tied low the port keeps working as a plain three-wire link.
// - The ready flag goes low whenever a new conversion word lands in the data register.
// - The ready flag goes high once the host has read one complete output word.
// - An unread word makes the ready flag go high for 500 master clock periods before the next update.
// - The ready flag also goes low when an on-chip calibration has finished.
// - The output shift path delivers the register chosen by the register-select bits.
// - Input words go to the selected register, except that the communication and data registers are never written.
// - A low sync input holds filter and calibration logic in reset, leaving the port and a low flag alone.
// - A low reset input returns control, interface and filter logic to the power-on state.

package adcsp_pkg;

  // ********************************************
  // register selection codes
  // ********************************************
  localparam logic [2:0] RS_COMM    = 3'h0;
  localparam logic [2:0] RS_MODE    = 3'h1;
  localparam logic [2:0] RS_FILT_HI = 3'h2;
  localparam logic [2:0] RS_FILT_LO = 3'h3;
  localparam logic [2:0] RS_TEST    = 3'h4;
  localparam logic [2:0] RS_DATA    = 3'h5;
  localparam logic [2:0] RS_ZCAL    = 3'h6;
  localparam logic [2:0] RS_FCAL    = 3'h7;

  // ********************************************
  // field positions and widths
  // ********************************************
  localparam int unsigned SHIFT_W     = 24;
  localparam int unsigned SHORT_W     = 8;
  localparam int unsigned COMM_RDY    = 7;
  localparam int unsigned COMM_RS_LSB = 4;
  localparam int unsigned COMM_RD     = 3;
  localparam int unsigned MODE_MD_LSB = 5;
  localparam logic [4:0]  SHORT_LAST  = 5'h07;
  localparam logic [4:0]  LONG_LAST   = 5'h17;

  // mode field codes: normal conversion, and the last code that starts a calibration
  localparam logic [2:0] MD_NORMAL   = 3'h0;
  localparam logic [2:0] MD_CAL_LAST = 3'h4;

  // ********************************************
  // reset values
  // ********************************************
  localparam logic [7:0]  MODE_RST    = 8'h00;
  localparam logic [7:0]  FILT_HI_RST = 8'h01;
  localparam logic [7:0]  FILT_LO_RST = 8'h40;
  localparam logic [7:0]  TEST_RST    = 8'h00;
  localparam logic [23:0] DATA_RST    = 24'h000000;
  localparam logic [23:0] ZCAL_RST    = 24'h800000;
  localparam logic [23:0] FCAL_RST    = 24'h555555;

  // ********************************************
  // timing counts, in master clock periods, and the FIFO depth in words
  // ********************************************
  localparam int unsigned HOLDOFF_MCLK_PERIODS = 500;
  localparam int unsigned CAL_MCLK_PERIODS     = 1000;
  localparam int unsigned FIFO_DEPTH_WORDS     = 8;

  // last bit index of the word belonging to a register selection
  function automatic logic [4:0] last_bit(input logic [2:0] rs);
    last_bit = (rs == RS_DATA || rs == RS_ZCAL || rs == RS_FCAL) ? LONG_LAST : SHORT_LAST;
  endfunction

endpackage

// file: rtl/adcsp_sync.sv
/*
  Two flip-flop synchroniser for a group of independent pin levels.
  Assumes each bit is a level; bits are not coherent with each other.
*/
`timescale 1ns/1ps
module adcsp_sync
#(
  parameter int unsigned      WIDTH   = 5,
  // idle level of each pin, so no false edge follows reset
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("adcsp_sync: WIDTH must be at least 1");
  end

  // ********************************************
  // two stages; the first is read by the second only
  // ********************************************
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta   <= RST_VAL;
      sync_o <= RST_VAL;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule // adcsp_sync

// file: rtl/adcsp_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides and a registered ready on the fill side.
  Assumes one clock; the drain side may stall for any time.
*/
`timescale 1ns/1ps
module adcsp_fifo
#(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 8
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin : g_bad_shape
    $error("adcsp_fifo: DEPTH must be a power of two of at least 2");
  end

  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_idx];

  always_comb
  begin
    next_count = count;
    if (push && !pop)
    begin
      next_count = count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_count = count - 1'b1;
    end
  end

  // ********************************************
  // pointers and level
  // ********************************************
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_idx     <= '0;
      rd_idx     <= '0;
      count      <= '0;
      in_ready_o <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_idx <= wr_idx + 1'b1;
      end
      if (pop)
      begin
        rd_idx <= rd_idx + 1'b1;
      end
      count      <= next_count;
      // registered, so a push and a full level never overlap
      in_ready_o <= (next_count != DEPTH[AW:0]);
    end
  end

  // ********************************************
  // storage
  // ********************************************
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_idx] <= in_data_i;
    end
  end

endmodule // adcsp_fifo

// file: rtl/adcsp_top.sv
/*
  Serial port, register file and output-word-ready flag of a sigma-delta converter.
  Assumes the host drives the serial clock idle high, changes input data on falling edges
  and samples output data on rising edges; conversion words arrive on a valid/ready port.
*/
`timescale 1ns/1ps
module adcsp_top
  import adcsp_pkg::*;
#(
  parameter int unsigned HOLDOFF_MCLK = HOLDOFF_MCLK_PERIODS,
  parameter int unsigned CAL_MCLK     = CAL_MCLK_PERIODS,
  parameter int unsigned FIFO_DEPTH   = FIFO_DEPTH_WORDS
)
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic        SCLK_I,
  input  wire logic        CS_B_I,
  input  wire logic        DIN_I,
  output logic             DOUT_O,
  output logic             DOUT_OE_O,
  output logic             OUTPUT_WORD_READY_N_O,
  input  wire logic        MCLK_I,
  input  wire logic        SYNC_B_I,
  input  wire logic [23:0] CONV_DATA_I,
  input  wire logic        CONV_VALID_I,
  output logic             CONV_READY_O,
  output logic             CAL_BUSY_O
);

  localparam int unsigned CNT_W = 16;

  typedef enum logic [1:0]
  {
    ADCSP_PH_COMM  = 2'b00,
    ADCSP_PH_WRITE = 2'b01,
    ADCSP_PH_READ  = 2'b10
  } adcsp_phase_e;

  typedef enum logic
  {
    ADCSP_UP_IDLE = 1'b0,
    ADCSP_UP_HOLD = 1'b1
  } adcsp_up_e;

  if (HOLDOFF_MCLK < 1 || HOLDOFF_MCLK >= (1 << CNT_W) || CAL_MCLK < 1 || CAL_MCLK >= (1 << CNT_W))
  begin : g_bad_counts
    $error("adcsp_top: master clock counts must lie between 1 and 65535");
  end

  // ********************************************
  // pin synchronisation and edge finding
  // ********************************************
  logic [4:0] pins_s;
  logic       s_sclk;
  logic       s_cs_b;
  logic       s_din;
  logic       s_mclk;
  logic       s_sync_b;
  logic       sclk_d;
  logic       mclk_d;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       mclk_rise;
  logic       selected;

  // reset to idle levels: sync high, select high, serial clock high
  adcsp_sync #(.WIDTH(5), .RST_VAL(5'h13)) u_sync
  (
    .clk_i     (SYS_CLK_I),
    .rst_b_i   (RST_B_I),
    .async_i   ({SYNC_B_I, MCLK_I, DIN_I, CS_B_I, SCLK_I}),
    .sync_o    (pins_s)
  );

  assign {s_sync_b, s_mclk, s_din, s_cs_b, s_sclk} = pins_s;

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      sclk_d <= 1'b1;
      mclk_d <= 1'b0;
    end
    else
    begin
      sclk_d <= s_sclk;
      mclk_d <= s_mclk;
    end
  end

  assign selected  = ~s_cs_b;
  assign sclk_rise = selected & s_sclk & ~sclk_d;
  assign sclk_fall = selected & ~s_sclk & sclk_d;
  assign mclk_rise = s_mclk & ~mclk_d;

  // ********************************************
  // serial shift engine
  // ********************************************
  adcsp_phase_e phase;
  logic [2:0]   sel_rs;
  logic [4:0]   bit_cnt;
  logic [23:0]  shift_in;
  logic [23:0]  shift_out;
  logic [23:0]  next_word;
  logic [4:0]   word_last;
  logic         word_done;
  logic         write_done;
  logic         data_reading;
  logic         data_read_done;
  logic [2:0]   next_rs;
  logic [23:0]  read_value;

  logic [7:0]   mode_reg;
  logic [7:0]   filt_hi;
  logic [7:0]   filt_lo;
  logic [7:0]   test_reg;
  logic [23:0]  data_reg;
  logic [23:0]  zcal_reg;
  logic [23:0]  fcal_reg;
  logic         ready_n;

  assign next_word      = {shift_in[22:0], s_din};
  assign next_rs        = next_word[COMM_RS_LSB +: 3];
  assign word_last      = (phase == ADCSP_PH_COMM) ? SHORT_LAST : last_bit(sel_rs);
  assign word_done      = sclk_rise & (bit_cnt == word_last);
  assign write_done     = word_done & (phase == ADCSP_PH_WRITE);
  assign data_reading   = (phase == ADCSP_PH_READ) & (sel_rs == RS_DATA);
  assign data_read_done = word_done & data_reading;

  always_comb
  begin
    read_value = '0;
    unique case (next_rs)
      RS_COMM:    read_value = {ready_n, next_word[6:0], 16'h0000};
      RS_MODE:    read_value = {mode_reg, 16'h0000};
      RS_FILT_HI: read_value = {filt_hi, 16'h0000};
      RS_FILT_LO: read_value = {filt_lo, 16'h0000};
      RS_TEST:    read_value = {test_reg, 16'h0000};
      RS_DATA:    read_value = data_reg;
      RS_ZCAL:    read_value = zcal_reg;
      RS_FCAL:    read_value = fcal_reg;
    endcase
  end

  // no frame edge needed; words chain on bit count alone
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      phase     <= ADCSP_PH_COMM;
      sel_rs    <= RS_COMM;
      bit_cnt   <= 5'h00;
      shift_in  <= 24'h000000;
      shift_out <= 24'h000000;
    end
    else if (sclk_rise)
    begin
      shift_in <= next_word;
      if (word_done)
      begin
        bit_cnt <= 5'h00;
        if (phase == ADCSP_PH_COMM)
        begin
          // channel bits select nothing inside this block
          sel_rs    <= next_rs;
          // snapshot, so a data update during the read cannot tear the word
          shift_out <= read_value;
          phase     <= next_word[COMM_RD] ? ADCSP_PH_READ : ADCSP_PH_WRITE;
        end
        else
        begin
          phase <= ADCSP_PH_COMM;
        end
      end
      else
      begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
    // first bit already stands before the first falling edge
    else if (sclk_fall && phase == ADCSP_PH_READ && bit_cnt != 5'h00)
    begin
      shift_out <= {shift_out[22:0], 1'b0};
    end
  end

  // ********************************************
  // calibration timer
  // ********************************************
  logic             cal_start;
  logic             cal_done;
  logic [CNT_W-1:0] cal_cnt;

  assign cal_start = write_done & (sel_rs == RS_MODE) & s_sync_b &
                     (next_word[MODE_MD_LSB +: 3] != MD_NORMAL) &
                     (next_word[MODE_MD_LSB +: 3] <= MD_CAL_LAST);
  assign cal_done  = CAL_BUSY_O & s_sync_b & mclk_rise & (cal_cnt == CNT_W'(CAL_MCLK - 1));

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      CAL_BUSY_O <= 1'b0;
      cal_cnt    <= '0;
    end
    else if (!s_sync_b)
    begin
      CAL_BUSY_O <= 1'b0;
      cal_cnt    <= '0;
    end
    else if (cal_start)
    begin
      CAL_BUSY_O <= 1'b1;
      cal_cnt    <= '0;
    end
    else if (CAL_BUSY_O && mclk_rise)
    begin
      cal_cnt <= cal_cnt + 1'b1;
      if (cal_done)
      begin
        CAL_BUSY_O <= 1'b0;
      end
    end
  end

  // ********************************************
  // writable registers
  // ********************************************
  // power-on values on reset
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      mode_reg <= MODE_RST;
      filt_hi  <= FILT_HI_RST;
      filt_lo  <= FILT_LO_RST;
      test_reg <= TEST_RST;
      zcal_reg <= ZCAL_RST;
      fcal_reg <= FCAL_RST;
    end
    else
    begin
      // data register has no write path
      if (write_done)
      begin
        unique case (sel_rs)
          RS_MODE:    mode_reg <= next_word[7:0];
          RS_FILT_HI: filt_hi  <= next_word[7:0];
          RS_FILT_LO: filt_lo  <= next_word[7:0];
          RS_TEST:    test_reg <= next_word[7:0];
          RS_ZCAL:    zcal_reg <= next_word;
          RS_FCAL:    fcal_reg <= next_word;
          RS_COMM,
          RS_DATA:    ;
        endcase
      end
      // calibration over, back to normal conversion
      if (cal_done)
      begin
        mode_reg[MODE_MD_LSB +: 3] <= MD_NORMAL;
      end
    end
  end

  // ********************************************
  // conversion word path and update sequencing
  // ********************************************
  logic [23:0]      fifo_data;
  logic             fifo_valid;
  logic             fifo_pop;
  logic             hold_start;
  adcsp_up_e        up_st;
  logic [CNT_W-1:0] hold_cnt;
  logic             may_update;

  adcsp_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .clk_i       (SYS_CLK_I),
    .rst_b_i     (RST_B_I),
    .in_data_i   (CONV_DATA_I),
    .in_valid_i  (CONV_VALID_I),
    .in_ready_o  (CONV_READY_O),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  // no update while sync holds the filter
  assign may_update = fifo_valid & s_sync_b & ~CAL_BUSY_O & ~data_reading;
  // unread word forces the hold-off window first
  assign hold_start = (up_st == ADCSP_UP_IDLE) & may_update & ~ready_n;
  assign fifo_pop   = may_update &
                      (((up_st == ADCSP_UP_IDLE) & ready_n) |
                       ((up_st == ADCSP_UP_HOLD) & (hold_cnt == CNT_W'(HOLDOFF_MCLK))));

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      up_st    <= ADCSP_UP_IDLE;
      hold_cnt <= '0;
    end
    else
    begin
      unique case (up_st)
        ADCSP_UP_IDLE:
        begin
          hold_cnt <= '0;
          if (hold_start)
          begin
            up_st <= ADCSP_UP_HOLD;
          end
        end
        ADCSP_UP_HOLD:
        begin
          if (!s_sync_b || fifo_pop)
          begin
            up_st <= ADCSP_UP_IDLE;
          end
          // count master clock periods of the window
          else if (mclk_rise && hold_cnt != CNT_W'(HOLDOFF_MCLK))
          begin
            hold_cnt <= hold_cnt + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      data_reg <= DATA_RST;
    end
    else if (fifo_pop)
    begin
      data_reg <= fifo_data;
    end
  end

  // ********************************************
  // ready flag
  // ********************************************
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      ready_n <= 1'b1;
    end
    // new word / calibration finished; low wins over a clear
    else if (fifo_pop || cal_done)
    begin
      ready_n <= 1'b0;
    end
    // full word read / window opens / calibration starts
    else if (data_read_done || hold_start || cal_start)
    begin
      ready_n <= 1'b1;
    end
  end

  // ********************************************
  // pin outputs
  // ********************************************
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      DOUT_O                <= 1'b0;
      DOUT_OE_O             <= 1'b0;
      OUTPUT_WORD_READY_N_O <= 1'b1;
    end
    else
    begin
      DOUT_O                <= shift_out[SHIFT_W-1];
      DOUT_OE_O             <= selected;
      OUTPUT_WORD_READY_N_O <= ready_n;
    end
  end

endmodule // adcsp_top

// file: verification/adcsp_checker.sv
/*
  Checker for the converter serial port: select, ready flag and calibration timing.
  Assumes it is bound to adcsp_top and sees only its pins.
*/
`timescale 1ns/1ps
module adcsp_checker
#(
  parameter int unsigned CAL_MCLK = 1000
)
(
  input  wire logic SYS_CLK_I,
  input  wire logic RST_B_I,
  input  wire logic CS_B_I,
  input  wire logic DOUT_O,
  input  wire logic DOUT_OE_O,
  input  wire logic OUTPUT_WORD_READY_N_O,
  input  wire logic MCLK_I,
  input  wire logic SYNC_B_I,
  input  wire logic CAL_BUSY_O
);
  logic [2:0] mclk_sh;
  int         cal_cnt;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);

  // same two-stage lag as the design, so both counts line up within one edge
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    if (!RST_B_I) mclk_sh <= 3'h0;
    else mclk_sh <= {mclk_sh[1:0], MCLK_I};

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    if (!RST_B_I) cal_cnt <= 0;
    else if (!CAL_BUSY_O) cal_cnt <= 0;
    else cal_cnt <= cal_cnt + int'(mclk_sh[1] & ~mclk_sh[2]);

  // ********************************************
  // properties
  // ********************************************
  property p_cs_off; CS_B_I [*4] |-> !DOUT_OE_O; endproperty
  a_cs_off: assert property (p_cs_off)
    else $error("dout driven while deselected");
  property p_cs_on; !CS_B_I [*4] |-> DOUT_OE_O; endproperty
  a_cs_on: assert property (p_cs_on)
    else $error("dout not driven while selected");
  property p_cs_hold; CS_B_I [*6] |=> $stable(DOUT_O); endproperty
  a_cs_hold: assert property (p_cs_hold)
    else $error("dout moved while deselected");
  property p_rst; $rose(RST_B_I) |-> OUTPUT_WORD_READY_N_O && !CAL_BUSY_O && !DOUT_OE_O && !DOUT_O; endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not at power-on state");
  property p_cal_start; $rose(CAL_BUSY_O) |-> ##[0:1] OUTPUT_WORD_READY_N_O; endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("flag low at calibration start");
  property p_cal_end; $fell(CAL_BUSY_O) && SYNC_B_I |-> ##[0:2] !OUTPUT_WORD_READY_N_O; endproperty
  a_cal_end: assert property (p_cal_end)
    else $error("flag not low after calibration");
  property p_cal_len; $fell(CAL_BUSY_O) && SYNC_B_I |-> cal_cnt + 1 >= CAL_MCLK && cal_cnt <= CAL_MCLK + 1; endproperty
  a_cal_len: assert property (p_cal_len)
    else $error("calibration length wrong");
  property p_sync; (CS_B_I && !SYNC_B_I) [*6] |=> !$rose(OUTPUT_WORD_READY_N_O); endproperty
  a_sync: assert property (p_sync)
    else $error("flag raised while sync low");
endmodule // adcsp_checker

bind adcsp_top adcsp_checker #(.CAL_MCLK(CAL_MCLK)) adcsp_checker_i (.SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I),
  .CS_B_I(CS_B_I), .DOUT_O(DOUT_O), .DOUT_OE_O(DOUT_OE_O), .OUTPUT_WORD_READY_N_O(OUTPUT_WORD_READY_N_O),
  .MCLK_I(MCLK_I), .SYNC_B_I(SYNC_B_I), .CAL_BUSY_O(CAL_BUSY_O));

// file: verification/adcsp_host.sv
/*
  Behavioural serial host: idle-high clock, data changed on falling and sampled on rising edges.
  Assumes callers start each task off the system clock edges.
*/
`timescale 1ns/1ps
module adcsp_host
(
  input  wire logic dout_i,
  input  wire logic dout_oe_i,
  output logic      sclk_o,
  output logic      cs_b_o,
  output logic      din_o
);
  logic line;

  // released line shows the inverse level, never a stale bit
  assign line = dout_oe_i ? dout_i : ~dout_i;

  initial
  begin
    sclk_o = 1'b1;
    cs_b_o = 1'b1;
    din_o  = 1'b0;
  end

  // ********************************************
  // transfers
  // ********************************************
  // select frames a word or stays low
  task automatic xfer(input int nb, input logic [23:0] wd, input bit hold, output logic [23:0] rd);
    rd = 24'h0;
    cs_b_o = 1'b0;
    #62.5;
    for (int i = nb - 1; i >= 0; i--)
    begin
      sclk_o = 1'b0;
      din_o  = wd[i];
      #62.5;
      sclk_o = 1'b1;
      rd     = {rd[22:0], line};
      #62.5;
    end
    if (!hold) cs_b_o = 1'b1;
    din_o = ~din_o;
    #62.5;
  endtask

  task automatic junk(input int n);
    #1.3;
    repeat (n)
    begin
      sclk_o = 1'b0;
      din_o  = ~din_o;
      #62.5;
      sclk_o = 1'b1;
      #62.5;
    end
  endtask
endmodule // adcsp_host

// file: verification/test_adc_serial_port_ready_signalling.sv
/*
  Self-checking bench for the converter serial port and ready flag, with a register model.
  Assumes adcsp_top with short hold-off and calibration counts and adcsp_host as master.
*/
`timescale 1ns/1ps
module test_adc_serial_port_ready_signalling;
  import adcsp_pkg::*;
  localparam int unsigned HOLD_N = 5;
  localparam int unsigned CAL_N  = 8;

  logic        sys_clk    = 1'b0;
  logic        rst_b      = 1'b0;
  logic        mclk       = 1'b0;
  logic        sync_b     = 1'b1;
  logic        conv_valid = 1'b0;
  logic [23:0] conv_data  = 24'h0;
  logic        sclk, cs_b, din, dout, dout_oe, flag_n, conv_ready, cal_busy;
  logic [23:0] mdl [8];
  logic [23:0] pushq [$];
  logic [23:0] got, w;
  int          n_mismatch = 0;
  int          n_checks   = 0;
  int          cnt;

  always #2.5 sys_clk = ~sys_clk;
  always #20 mclk = ~mclk;

  adcsp_top #(.HOLDOFF_MCLK(HOLD_N), .CAL_MCLK(CAL_N), .FIFO_DEPTH(FIFO_DEPTH_WORDS)) adcsp_top_i (
    .SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .SCLK_I(sclk), .CS_B_I(cs_b), .DIN_I(din), .DOUT_O(dout),
    .DOUT_OE_O(dout_oe), .OUTPUT_WORD_READY_N_O(flag_n), .MCLK_I(mclk), .SYNC_B_I(sync_b),
    .CONV_DATA_I(conv_data), .CONV_VALID_I(conv_valid), .CONV_READY_O(conv_ready), .CAL_BUSY_O(cal_busy));
  adcsp_host adcsp_host_i (.dout_i(dout), .dout_oe_i(dout_oe), .sclk_o(sclk), .cs_b_o(cs_b), .din_o(din));

  // ********************************************
  // tasks
  // ********************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic ran_out();
    n_mismatch++;
    $display("FAIL %0t wait ran out", $time);
    summarize();
  endtask

  task automatic cmp_word(input logic [23:0] g, input logic [23:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL %0t word %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_bit(input logic g, input logic e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL %0t bit %b expected %b", $time, g, e);
    end
  endtask

  // flag (sel 0) or busy (sel 1); counts mclk rises seen while waiting
  task automatic wait_for(input bit sel, input logic v, input int lim);
    logic m;
    m = mclk;
    cnt = 0;
    for (int i = 0; (sel ? cal_busy : flag_n) !== v; i++)
    begin
      if (i == lim) ran_out();
      @(negedge sys_clk);
      cnt += int'(mclk & ~m);
      m = mclk;
    end
  endtask

  task automatic spi(input logic [2:0] rs, input bit rd, input logic [23:0] wd, input bit hold,
                     output logic [23:0] r);
    logic [23:0] c;
    @(posedge sys_clk);
    #1.3;
    adcsp_host_i.xfer(8, {17'h0, rs, rd, 3'h0}, 1'b1, c);
    adcsp_host_i.xfer(rs >= RS_DATA ? 24 : 8, wd, hold, r);
    @(negedge sys_clk);
  endtask

  // read only once the flag is low
  task automatic rd_data(output logic [23:0] r);
    wait_for(1'b0, 1'b0, 4000);
    spi(RS_DATA, 1'b1, 24'h0, 1'b0, r);
  endtask

  task automatic push(input logic [23:0] d);
    @(posedge sys_clk);
    conv_data  <= d;
    conv_valid <= 1'b1;
    @(negedge sys_clk);
    for (int i = 0; conv_ready !== 1'b1; i++)
    begin
      if (i == 50) ran_out();
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    conv_valid <= 1'b0;
    conv_data  <= ~d;
    pushq.push_back(d);
    @(negedge sys_clk);
  endtask

  task automatic init_mdl();
    mdl = '{24'h0, 24'(MODE_RST), 24'(FILT_HI_RST), 24'(FILT_LO_RST), 24'(TEST_RST), DATA_RST, ZCAL_RST, FCAL_RST};
  endtask

  task automatic chk_regs();
    logic [23:0] r;
    for (int rs = 0; rs < 8; rs++)
    begin
      spi(3'(rs), 1'b1, 24'h0, 1'b0, r);
      cmp_word(r, rs == 0 ? {16'h0, flag_n, 7'h08} : mdl[rs]);
    end
  endtask

  // ********************************************
  // sequence
  // ********************************************
  initial
  begin
    got = 24'($urandom(81577));
    init_mdl();
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(negedge sys_clk);
    chk_regs();
    for (int rs = 1; rs < 8; rs++)
    begin
      w = 24'($urandom) & (rs < 5 ? 24'hff : 24'hffffff);
      if (rs == 1) w[7:5] = 3'h0;
      if (rs == 4) w = 24'(TEST_RST);
      spi(3'(rs), 1'b0, w, 1'b0, got);
      if (rs != 5) mdl[rs] = w;
    end
    chk_regs();
    w = 24'($urandom) & 24'hff;
    spi(RS_FILT_LO, 1'b0, w, 1'b1, got);
    spi(RS_FILT_LO, 1'b1, 24'h0, 1'b1, got);
    cmp_word(got, w);
    mdl[3] = w;
    spi(RS_FILT_LO, 1'b1, 24'h0, 1'b0, got);
    cmp_word(got, w);
    adcsp_host_i.junk(16);
    chk_regs();
    w = 24'($urandom);
    push(w);
    rd_data(got);
    cmp_word(got, w);
    cmp_bit(flag_n, 1'b1);
    push(24'($urandom));
    wait_for(1'b0, 1'b0, 400);
    w = 24'($urandom);
    push(w);
    wait_for(1'b0, 1'b1, 400);
    wait_for(1'b0, 1'b0, 4000);
    cmp_bit(cnt + 1 >= HOLD_N && cnt <= HOLD_N + 1, 1'b1);
    rd_data(got);
    cmp_word(got, w);
    w = 24'($urandom);
    push(w);
    wait_for(1'b0, 1'b0, 400);
    @(posedge sys_clk);
    sync_b <= 1'b0;
    repeat (20) @(negedge sys_clk);
    cmp_bit(flag_n, 1'b0);
    spi(RS_MODE, 1'b1, 24'h0, 1'b0, got);
    cmp_word(got, mdl[1]);
    spi(RS_DATA, 1'b1, 24'h0, 1'b0, got);
    cmp_word(got, w);
    pushq.delete();
    for (int i = 0; i < 20 && conv_ready === 1'b1; i++) push(24'($urandom));
    cmp_word(24'(pushq.size()), 24'(FIFO_DEPTH_WORDS));
    cmp_bit(flag_n, 1'b1);
    @(posedge sys_clk);
    sync_b <= 1'b1;
    // skipped words are fine, but order and the last word must hold
    while (pushq.size() > 0)
    begin
      rd_data(got);
      while (pushq.size() > 0 && pushq[0] !== got) void'(pushq.pop_front());
      cmp_bit(pushq.size() > 0, 1'b1);
      if (pushq.size() > 0) void'(pushq.pop_front());
    end
    for (int md = 1; md < 5; md++)
    begin
      w = {16'h0, 3'(md), 5'($urandom)};
      spi(RS_MODE, 1'b0, w, 1'b0, got);
      wait_for(1'b1, 1'b1, 100);
      cmp_bit(flag_n, 1'b1);
      wait_for(1'b1, 1'b0, 400);
      repeat (2) @(negedge sys_clk);
      cmp_bit(flag_n, 1'b0);
      mdl[1] = {19'h0, w[4:0]};
      spi(RS_MODE, 1'b1, 24'h0, 1'b0, got);
      cmp_word(got, mdl[1]);
    end
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(negedge sys_clk);
    cmp_bit(flag_n, 1'b1);
    init_mdl();
    chk_regs();
    summarize();
  end
endmodule // test_adc_serial_port_ready_signalling
